// [core/smf_pkg.sv]
package smf_pkg;

	// ************************************************************
	// coding schemes selecting marker length and pattern
	// ************************************************************
	typedef enum logic [3:0] {
		SMF_UNCODED,
		SMF_CONV,
		SMF_RS,
		SMF_RS_CONV,
		SMF_TURBO_12,
		SMF_TURBO_13,
		SMF_TURBO_14,
		SMF_TURBO_16,
		SMF_LDPC_12,
		SMF_LDPC_23,
		SMF_LDPC_45,
		SMF_LDPC_78
	} smf_scheme_e;

	// ************************************************************
	// marker patterns, first transmitted bit is the msb
	// ************************************************************
	localparam int SMF_PAT_W = 192;
	localparam logic [31:0] SMF_ASM_32 = 32'h1ACFFC1D;
	localparam logic [63:0] SMF_ASM_64 = 64'h034776C7272895B0;
	localparam logic [95:0] SMF_ASM_96 = 96'h25D5C0CE8990F6C9461BF79C;
	localparam logic [63:0] SMF_ASM_128_TAIL = 64'hFCB88938D8D76A4F;
	localparam logic [95:0] SMF_ASM_192_TAIL = 96'hDA2A3F31766F0936B9E40863;

	// ************************************************************
	// register map of the framer, byte addresses
	// ************************************************************
	localparam logic [7:0] SMF_REG_CTRL = 8'h00;
	localparam logic [7:0] SMF_REG_LEN = 8'h04;
	localparam logic [7:0] SMF_REG_STATUS = 8'h08;
	localparam logic [7:0] SMF_REG_FRAMES = 8'h0C;
	localparam int SMF_CTRL_EN_BIT = 0;
	localparam int SMF_CTRL_SCHEME_LSB = 4;
	localparam int SMF_STAT_BUSY_BIT = 0;
	localparam int SMF_STAT_UNDER_BIT = 1;
	localparam logic [15:0] SMF_LEN_RESET = 16'h2000;
	localparam logic [3:0] SMF_SCHEME_RESET = 4'h0;
	localparam logic [7:0] SMF_MLEN_RESET = 8'h20;

	// marker length in bits for a scheme
	function automatic logic [7:0] smf_asm_len(input logic [3:0] scheme);
		case (scheme)
			SMF_TURBO_12, SMF_LDPC_12, SMF_LDPC_23, SMF_LDPC_45: smf_asm_len = 8'h40;
			SMF_TURBO_13: smf_asm_len = 8'h60;
			SMF_TURBO_14: smf_asm_len = 8'h80;
			SMF_TURBO_16: smf_asm_len = 8'hC0;
			default: smf_asm_len = 8'h20;
		endcase
	endfunction : smf_asm_len

	// marker pattern, left aligned in SMF_PAT_W bits
	function automatic logic [191:0] smf_asm_pat(input logic [3:0] scheme);
		case (scheme)
			SMF_TURBO_12, SMF_LDPC_12, SMF_LDPC_23, SMF_LDPC_45:
				smf_asm_pat = {SMF_ASM_64, 128'h0};
			SMF_TURBO_13: smf_asm_pat = {SMF_ASM_96, 96'h0};
			SMF_TURBO_14: smf_asm_pat = {SMF_ASM_64, SMF_ASM_128_TAIL, 64'h0};
			SMF_TURBO_16: smf_asm_pat = {SMF_ASM_96, SMF_ASM_192_TAIL};
			default: smf_asm_pat = {SMF_ASM_32, 160'h0};
		endcase
	endfunction : smf_asm_pat

	// true where the marker runs through the inner convolutional encoder
	function automatic logic smf_uses_conv(input logic [3:0] scheme);
		smf_uses_conv = (scheme == SMF_CONV) || (scheme == SMF_RS_CONV);
	endfunction : smf_uses_conv

endpackage : smf_pkg

// [core/smf_link_if.sv]
`timescale 1ns/1ps
interface smf_link_if;
	logic tx_bit;
	logic tx_valid;
	logic tx_asm;
	logic tx_conv_en;

	// ************************************************************
	// framer drives the stream, synchronizer receives it
	// ************************************************************
	modport framer (
		output tx_bit,
		output tx_valid,
		output tx_asm,
		output tx_conv_en
	);
	modport sync (
		input tx_bit,
		input tx_valid,
		input tx_asm,
		input tx_conv_en
	);
endinterface : smf_link_if

// [core/smf_framer.sv]
// Functional notes
// - continuous equal units, marker between each pair
// - marker flagged for convolutional encoding too
// - marker bypasses outer encoder, inner only
// - uncoded data uses 32-bit 1ACFFC1D marker
// - turbo marker length is 32/r bits
// - turbo 1/2 uses 64-bit marker
// - turbo 1/3 uses 96-bit marker
// - turbo 1/4 uses 128-bit marker
// - turbo 1/6 uses 192-bit marker
// - ldpc 7/8 uses the 32-bit marker
// - ldpc 1/2, 2/3, 4/5 use 64-bit marker
// - marker directly precedes its unit
// - marker follows previous unit, no gap bits
// - basic convolutional receiver searches either domain
// - punctured convolutional receiver searches decoded bits
// - turbo/ldpc receiver searches raw channel symbols
// - receiver finds pattern, confirms at next marker, then locks
// - block encoders and decoders never see marker
`timescale 1ns/1ps
module smf_framer (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [7:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	output logic [31:0] wb_dat_o,
	output logic wb_ack_o,
	input wire logic src_bit_i,
	input wire logic src_valid_i,
	output logic src_ready_o,
	smf_link_if.framer link
);

	typedef enum logic [1:0] {
		ST_IDLE,
		ST_MARK,
		ST_BODY
	} smf_fr_state_e;

	// ************************************************************
	// registers
	// ************************************************************
	smf_fr_state_e state_q, state_d;
	logic en_q, en_d;
	logic [3:0] scheme_q, scheme_d;
	logic [15:0] len_q, len_d;
	logic under_q, under_d;
	logic [31:0] frames_q, frames_d;
	logic [3:0] act_scheme_q, act_scheme_d;
	logic [15:0] act_len_q, act_len_d;
	logic [7:0] act_mlen_q, act_mlen_d;
	logic [191:0] pat_q, pat_d;
	logic [15:0] cnt_q, cnt_d;
	logic bit_q, bit_d;
	logic valid_q, valid_d;
	logic asm_q, asm_d;
	logic ack_q;
	logic [31:0] rdat_q, rdat_d;

	// ************************************************************
	// bus decode
	// ************************************************************
	wire logic bus_req = wb_cyc_i & wb_stb_i & ~ack_q;
	wire logic bus_wr = bus_req & wb_we_i;
	wire logic sel_ctrl = wb_adr_i == smf_pkg::SMF_REG_CTRL;
	wire logic sel_len = wb_adr_i == smf_pkg::SMF_REG_LEN;
	wire logic sel_stat = wb_adr_i == smf_pkg::SMF_REG_STATUS;
	wire logic sel_frames = wb_adr_i == smf_pkg::SMF_REG_FRAMES;
	wire logic idle = state_q == ST_IDLE;
	wire logic start = idle & en_q & (len_q != 16'h0000);
	wire logic mark_last = cnt_q == {8'h00, act_mlen_q - 8'h01};
	wire logic body_last = cnt_q == (act_len_q - 16'h0001);
	wire logic body_take = (state_q == ST_BODY) & src_valid_i;
	wire logic under_set = (state_q == ST_BODY) & ~src_valid_i;
	wire logic under_clr = bus_wr & sel_stat & wb_sel_i[0] & wb_dat_i[smf_pkg::SMF_STAT_UNDER_BIT];

	// upstream only offered during the unit body, never during the marker
	assign src_ready_o = state_q == ST_BODY;
	assign link.tx_bit = bit_q;
	assign link.tx_valid = valid_q;
	assign link.tx_asm = asm_q;
	assign link.tx_conv_en = smf_pkg::smf_uses_conv(act_scheme_q);
	assign wb_ack_o = ack_q;
	assign wb_dat_o = rdat_q;

	// ************************************************************
	// register writes and read data
	// ************************************************************
	always_comb begin
		en_d = en_q;
		scheme_d = scheme_q;
		len_d = len_q;
		rdat_d = 32'h0000_0000;
		if (bus_wr && sel_ctrl && wb_sel_i[0]) begin
			en_d = wb_dat_i[smf_pkg::SMF_CTRL_EN_BIT];
			if (idle && !en_q) begin
				scheme_d = wb_dat_i[smf_pkg::SMF_CTRL_SCHEME_LSB +: 4];
			end
		end
		if (bus_wr && sel_len && idle && !en_q) begin
			if (wb_sel_i[0]) begin
				len_d[7:0] = wb_dat_i[7:0];
			end
			if (wb_sel_i[1]) begin
				len_d[15:8] = wb_dat_i[15:8];
			end
		end
		if (bus_req && !wb_we_i) begin
			if (sel_ctrl) begin
				rdat_d = {24'h00_0000, scheme_q, 3'h0, en_q};
			end else if (sel_len) begin
				rdat_d = {16'h0000, len_q};
			end else if (sel_stat) begin
				rdat_d = {16'h0000, act_mlen_q, 6'h00, under_q, ~idle};
			end else if (sel_frames) begin
				rdat_d = frames_q;
			end
		end
	end

	// ************************************************************
	// stream sequencer: marker then unit, back to back
	// ************************************************************
	always_comb begin
		state_d = state_q;
		act_scheme_d = act_scheme_q;
		act_len_d = act_len_q;
		act_mlen_d = act_mlen_q;
		pat_d = pat_q;
		cnt_d = cnt_q;
		frames_d = frames_q;
		bit_d = 1'b0;
		valid_d = 1'b0;
		asm_d = 1'b0;
		under_d = under_set | (under_q & ~under_clr);
		case (state_q)
			ST_IDLE: begin
				if (start) begin
					act_scheme_d = scheme_q;
					act_len_d = len_q;
					act_mlen_d = smf_pkg::smf_asm_len(scheme_q);
					pat_d = smf_pkg::smf_asm_pat(scheme_q);
					cnt_d = 16'h0000;
					state_d = ST_MARK;
				end
			end
			ST_MARK: begin
				bit_d = pat_q[191];
				valid_d = 1'b1;
				asm_d = 1'b1;
				pat_d = {pat_q[190:0], 1'b0};
				cnt_d = cnt_q + 16'h0001;
				if (mark_last) begin
					cnt_d = 16'h0000;
					state_d = ST_BODY;
				end
			end
			ST_BODY: begin
				if (body_take) begin
					bit_d = src_bit_i;
					valid_d = 1'b1;
					cnt_d = cnt_q + 16'h0001;
					if (body_last) begin
						cnt_d = 16'h0000;
						frames_d = frames_q + 32'h0000_0001;
						if (en_q) begin
							pat_d = smf_pkg::smf_asm_pat(act_scheme_q);
							state_d = ST_MARK;
						end else begin
							state_d = ST_IDLE;
						end
					end
				end
			end
			default: begin
				state_d = ST_IDLE;
			end
		endcase
	end

	// ************************************************************
	// flops
	// ************************************************************
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			state_q <= ST_IDLE;
			en_q <= 1'b0;
			scheme_q <= smf_pkg::SMF_SCHEME_RESET;
			len_q <= smf_pkg::SMF_LEN_RESET;
			under_q <= 1'b0;
			frames_q <= 32'h0000_0000;
			act_scheme_q <= smf_pkg::SMF_SCHEME_RESET;
			act_len_q <= smf_pkg::SMF_LEN_RESET;
			act_mlen_q <= smf_pkg::SMF_MLEN_RESET;
			pat_q <= 192'h0;
			cnt_q <= 16'h0000;
			bit_q <= 1'b0;
			valid_q <= 1'b0;
			asm_q <= 1'b0;
			ack_q <= 1'b0;
			rdat_q <= 32'h0000_0000;
		end else begin
			state_q <= state_d;
			en_q <= en_d;
			scheme_q <= scheme_d;
			len_q <= len_d;
			under_q <= under_d;
			frames_q <= frames_d;
			act_scheme_q <= act_scheme_d;
			act_len_q <= act_len_d;
			act_mlen_q <= act_mlen_d;
			pat_q <= pat_d;
			cnt_q <= cnt_d;
			bit_q <= bit_d;
			valid_q <= valid_d;
			asm_q <= asm_d;
			ack_q <= bus_req; // single cycle answer, dropped next cycle
			rdat_q <= rdat_d;
		end
	end

endmodule : smf_framer

// [core/smf_sync.sv]
`timescale 1ns/1ps
module smf_sync (
	input wire logic clk_i,
	input wire logic rst_i,
	smf_link_if.sync link,
	input wire logic [3:0] scheme_i,
	input wire logic [15:0] frame_len_i,
	output logic locked_o,
	output logic dat_bit_o,
	output logic dat_valid_o,
	output logic dat_sou_o
);

	typedef enum logic [1:0] {
		SY_HUNT,
		SY_VERIFY,
		SY_LOCK
	} smf_sy_state_e;

	// ************************************************************
	// registers and pattern match
	// ************************************************************
	smf_sy_state_e state_q, state_d;
	logic [191:0] shift_q;
	logic [16:0] cnt_q, cnt_d;
	logic bit_q, valid_q, sou_q;

	wire logic [7:0] mlen = smf_pkg::smf_asm_len(scheme_i);
	wire logic [7:0] pad = 8'hC0 - mlen;
	wire logic [191:0] pat_r = smf_pkg::smf_asm_pat(scheme_i) >> pad;
	wire logic [191:0] mask = {192{1'b1}} >> pad;
	wire logic [191:0] shift_d = {shift_q[190:0], link.tx_bit};
	// link bits precede any inner convolutional encoder: the match runs in the decoded
	// domain for convolutional schemes and on raw channel symbols for turbo and ldpc
	wire logic hit = ((shift_d ^ pat_r) & mask) == 192'h0;
	wire logic [16:0] period = {1'b0, frame_len_i} + {9'h000, mlen};
	wire logic at_mark_end = cnt_q == (period - 17'h00001);
	wire logic in_body = cnt_q < {1'b0, frame_len_i};

	assign locked_o = state_q == SY_LOCK;
	assign dat_bit_o = bit_q;
	assign dat_valid_o = valid_q;
	assign dat_sou_o = sou_q;

	// ************************************************************
	// hunt, verify at next expected marker, lock, back to hunt on a missed marker
	// ************************************************************
	always_comb begin
		state_d = state_q;
		cnt_d = cnt_q;
		if (link.tx_valid) begin
			case (state_q)
				SY_HUNT: begin
					if (hit) begin
						cnt_d = 17'h00000;
						state_d = SY_VERIFY;
					end
				end
				SY_VERIFY, SY_LOCK: begin
					cnt_d = cnt_q + 17'h00001;
					if (at_mark_end) begin
						cnt_d = 17'h00000;
						state_d = hit ? SY_LOCK : SY_HUNT;
					end
				end
				default: begin
					state_d = SY_HUNT;
				end
			endcase
		end
	end

	// shifter and body bit output, marker bits stripped
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			state_q <= SY_HUNT;
			shift_q <= 192'h0;
			cnt_q <= 17'h00000;
			bit_q <= 1'b0;
			valid_q <= 1'b0;
			sou_q <= 1'b0;
		end else begin
			state_q <= state_d;
			cnt_q <= cnt_d;
			if (link.tx_valid) begin
				shift_q <= shift_d;
			end
			bit_q <= link.tx_bit;
			valid_q <= link.tx_valid & (state_q == SY_LOCK) & in_body;
			sou_q <= link.tx_valid & (state_q == SY_LOCK) & (cnt_q == 17'h00000);
		end
	end

endmodule : smf_sync

// [sim/smf_checker.sv]
`timescale 1ns/1ps
module smf_checker (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic tx_bit_i,
	input wire logic tx_valid_i,
	input wire logic tx_asm_i,
	input wire logic tx_conv_en_i
);
	// ************************************************************
	// run-length helpers for markers and units
	// ************************************************************
	logic [7:0] mlen_q;
	logic [15:0] unit_q;
	logic [15:0] prev_q;
	logic asm_q;

	default clocking cb @(posedge clk_i);
	endclocking
	default disable iff (rst_i);

	// marker run, body count since last marker, body count of the unit before
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			mlen_q <= 8'h00;
			unit_q <= 16'h0000;
			prev_q <= 16'h0000;
			asm_q <= 1'b0;
		end else begin
			mlen_q <= tx_asm_i ? mlen_q + 8'h01 : 8'h00;
			unit_q <= tx_asm_i ? 16'h0000 : unit_q + 16'(tx_valid_i);
			prev_q <= (tx_asm_i && !asm_q && unit_q != 16'h0000) ? unit_q : prev_q;
			asm_q <= tx_asm_i;
		end
	end

	// ************************************************************
	// stream properties
	// ************************************************************
	asm_valid_a: assert property (tx_asm_i |-> tx_valid_i)
		else $error("marker bit without valid");
	asm_lead_a: assert property ($rose(tx_asm_i) |-> !tx_bit_i ##1 (tx_asm_i && !tx_bit_i))
		else $error("marker does not open with its leading zeros");
	asm_len_a: assert property ($fell(tx_asm_i) |-> mlen_q inside {8'h20, 8'h40, 8'h60, 8'h80, 8'hC0})
		else $error("marker length not a legal size");
	asm_run_a: assert property ($rose(tx_asm_i) |-> tx_asm_i [*8])
		else $error("marker broken up early");
	conv_hold_a: assert property (tx_asm_i |=> $stable(tx_conv_en_i))
		else $error("coding flag changed inside a frame");
	unit_equal_a: assert property ($rose(tx_asm_i) && prev_q != 16'h0000 |-> unit_q == prev_q)
		else $error("unit length differs from previous unit");
	unit_bound_a: assert property (prev_q != 16'h0000 |-> unit_q <= prev_q)
		else $error("unit longer than previous unit");
	unit_end_a: assert property (tx_valid_i && !tx_asm_i && prev_q != 16'h0000
		&& unit_q + 16'h0001 == prev_q |=> tx_asm_i || !tx_valid_i)
		else $error("extra bits after a complete unit");

	cover property ($fell(tx_asm_i) && mlen_q == 8'hC0);
	cover property ($rose(tx_asm_i) && tx_conv_en_i);
	cover property ($rose(tx_asm_i) && prev_q != 16'h0000);
endmodule : smf_checker

// [sim/sync_marker_framer_tb.sv]
`timescale 1ns/1ps
module sync_marker_framer_tb;
	// ************************************************************
	// stimulus, reference model and checks
	// ************************************************************
	localparam logic [15:0] ULEN = 16'h0028;
	logic clk_i = 1'b0;
	logic rst_i = 1'b1;
	logic cyc = 1'b0;
	logic stb = 1'b0;
	logic we = 1'b0;
	logic [7:0] adr = 8'h00;
	logic [31:0] wdat = 32'h0;
	logic [31:0] rdat;
	logic ack;
	logic src_bit = 1'b0;
	logic rdy;
	logic [3:0] sch = 4'h0;
	logic locked;
	logic dv;
	logic dbit;
	logic dsou;
	logic pb = 1'b0;
	logic pv = 1'b0;
	logic pfirst = 1'b0;
	logic plock = 1'b0;
	logic [191:0] pat = 192'h0;
	logic conv = 1'b0;
	logic [31:0] rd;
	logic body_q[$];
	logic [7:0] ml_t[12] = '{8'h20, 8'h20, 8'h20, 8'h20, 8'h40, 8'h60, 8'h80, 8'hC0,
		8'h40, 8'h40, 8'h40, 8'h20};
	int failures = 0;
	int comparisons = 0;
	int cycles = 0;
	int pos = 0;
	int ml = 32;
	int units = 0;
	int n;

	smf_link_if link_inst();
	smf_framer smf_framer_inst (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb),
		.wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hF), .wb_dat_i(wdat), .wb_dat_o(rdat),
		.wb_ack_o(ack), .src_bit_i(src_bit), .src_valid_i(1'b1), .src_ready_o(rdy),
		.link(link_inst));
	smf_sync smf_sync_inst (.clk_i(clk_i), .rst_i(rst_i), .link(link_inst), .scheme_i(sch),
		.frame_len_i(ULEN), .locked_o(locked), .dat_bit_o(dbit), .dat_valid_o(dv),
		.dat_sou_o(dsou));
	smf_checker smf_checker_inst (.clk_i(clk_i), .rst_i(rst_i), .tx_bit_i(link_inst.tx_bit),
		.tx_valid_i(link_inst.tx_valid), .tx_asm_i(link_inst.tx_asm),
		.tx_conv_en_i(link_inst.tx_conv_en));

	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		comparisons++;
		if (seen !== exp) begin
			failures++;
			$display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask : chk

	task automatic tally_and_finish();
		$display("comparisons %0d failures %0d", comparisons, failures);
		if (failures == 0 && comparisons > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask : tally_and_finish

	// one classic bus cycle, held until ack is sampled high at a rising edge
	task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge clk_i);
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w;
		adr <= a;
		wdat <= d;
		do @(posedge clk_i); while (ack !== 1'b1);
		rd = rdat;
		cyc <= 1'b0;
		stb <= 1'b0;
	endtask : wb

	// expected marker, left aligned, first sent bit at the top
	function automatic logic [191:0] pat_of(input int s);
		case (s)
			4, 8, 9, 10: return {smf_pkg::SMF_ASM_64, 128'h0};
			5: return {smf_pkg::SMF_ASM_96, 96'h0};
			6: return {smf_pkg::SMF_ASM_64, smf_pkg::SMF_ASM_128_TAIL, 64'h0};
			7: return {smf_pkg::SMF_ASM_96, smf_pkg::SMF_ASM_192_TAIL};
			default: return {smf_pkg::SMF_ASM_32, 160'h0};
		endcase
	endfunction : pat_of

	// clock
	initial begin
		forever #50 clk_i = ~clk_i;
	end

	// hang guard
	always @(posedge clk_i) begin
		cycles++;
		if (cycles == 40000) begin
			failures++;
			tally_and_finish();
		end
	end

	// random unit data
	always @(posedge clk_i) src_bit <= 1'($urandom);

	// link model: marker then body, no gaps, pops before the new bit is queued
	always @(negedge clk_i) begin
		// receiver output lags the link by one cycle: body bits of locked units only
		chk(32'(dv), 32'(pv && plock));
		if (dv === 1'b1) chk(32'(dbit), 32'(pb));
		chk(32'(dsou), 32'(pv && plock && pfirst));
		pb = link_inst.tx_bit;
		pv = (link_inst.tx_valid === 1'b1) && (pos >= ml);
		pfirst = pos == ml;
		plock = locked;
		if (link_inst.tx_valid === 1'b1) begin
			chk(32'(link_inst.tx_asm), 32'(pos < ml));
			if (pos < ml) chk(32'(link_inst.tx_bit), 32'(pat[191 - pos]));
			else chk(32'(link_inst.tx_bit), 32'(body_q.pop_front()));
			chk(32'(link_inst.tx_conv_en), 32'(conv));
			pos = pos + 1;
			if (pos == ml + int'(ULEN)) begin
				pos = 0;
				units++;
			end
		end else if (pos != 0) chk(32'(link_inst.tx_valid), 32'h1);
		if (rdy === 1'b1) body_q.push_back(src_bit);
	end

	// main sequence: every scheme in turn
	initial begin
		void'($urandom(32'hE1E2));
		repeat (20) @(posedge clk_i);
		rst_i <= 1'b0;
		wb(1'b0, smf_pkg::SMF_REG_LEN, 32'h0);
		chk(rd, 32'(smf_pkg::SMF_LEN_RESET));
		wb(1'b0, 8'h10, 32'h0);
		chk(rd, 32'h0);
		wb(1'b1, smf_pkg::SMF_REG_LEN, 32'(ULEN));
		for (int s = 0; s < 12; s++) begin
			ml = int'(ml_t[s]);
			pat = pat_of(s);
			conv = (s == 1) || (s == 3);
			sch <= 4'(s);
			wb(1'b1, smf_pkg::SMF_REG_CTRL, 32'(s) << 4);
			wb(1'b1, smf_pkg::SMF_REG_CTRL, (32'(s) << 4) | 32'h1);
			wb(1'b1, smf_pkg::SMF_REG_LEN, 32'h5);
			n = units + 4;
			wait (units >= n);
			chk(32'(locked), 32'h1);
			wb(1'b1, smf_pkg::SMF_REG_CTRL, 32'(s) << 4);
			do wb(1'b0, smf_pkg::SMF_REG_STATUS, 32'h0); while (rd[0] !== 1'b0);
			chk(rd, 32'(ml_t[s]) << 8);
			wb(1'b0, smf_pkg::SMF_REG_FRAMES, 32'h0);
			chk(rd, 32'(units));
			wb(1'b0, smf_pkg::SMF_REG_LEN, 32'h0);
			chk(rd, 32'(ULEN));
			$display("scheme %0d done", s);
		end
		tally_and_finish();
	end
endmodule : sync_marker_framer_tb
